// file: hdl/bist_regs_pkg.sv
package bist_regs_pkg;

   // Register offsets on the serial control bus.
   localparam logic [7:0] ERR_CNT_ADDR    = 8'h25;
   localparam logic [7:0] HIGH_TIME_ADDR  = 8'h26;
   localparam logic [7:0] LOW_TIME_ADDR   = 8'h27;
   localparam logic [7:0] AUDIO_CTRL_ADDR = 8'h28;

   // Reset values, and the error counter's saturation value.
   localparam logic [7:0] ERR_CNT_RST     = 8'h00;
   localparam logic [7:0] HIGH_TIME_RST   = 8'h83;
   localparam logic [7:0] LOW_TIME_RST    = 8'h84;
   localparam logic [7:0] AUDIO_CTRL_RST  = 8'h00;
   localparam logic [7:0] ERR_CNT_MAX     = 8'hff;

   // Audio path control field positions and the mask of implemented bits.
   localparam int unsigned FC_BLOCK_BIT   = 7;
   localparam int unsigned AUX_I2S_BIT    = 3;
   localparam int unsigned I2S_OFF_BIT    = 2;
   localparam int unsigned SURROUND_BIT   = 0;
   localparam logic [7:0] AUDIO_CTRL_MASK = 8'h8d;

   // Timing: one count of the clock-time fields is one core clock of 100 ns, the 50 ns unit rounded up.
   localparam int unsigned CLK_PERIOD_NS  = 100;
   localparam int unsigned SCL_UNIT_NS    = 50;
   localparam int unsigned SCL_UNIT_CYC   =
      (SCL_UNIT_NS / CLK_PERIOD_NS < 1) ? 1 : SCL_UNIT_NS / CLK_PERIOD_NS;
   localparam logic [7:0] PRE_LOAD        = 8'(SCL_UNIT_CYC - 1);

   // A programmed count of zero still gives a phase of one unit.
   function automatic logic [7:0] at_least_one(input logic [7:0] v);
      return (v == 8'h00) ? 8'h01 : v;
   endfunction

   // Saturating increment for the error counter.
   function automatic logic [7:0] sat_inc(input logic [7:0] v);
      return (v == ERR_CNT_MAX) ? v : v + 8'h01;
   endfunction

endpackage

// file: hdl/scl_timing_if.sv
`timescale 1ns/100ps
interface scl_timing_if;
   logic [7:0] hi;
   logic [7:0] lo;
   logic       master_en;
   logic       scl;
   logic       scl_oe_n;
   logic       setup_req;
   logic       setup_done;

   modport ctrl   (output hi, lo, master_en, setup_req,
                   input  scl, scl_oe_n, setup_done);
   modport master (input  hi, lo, master_en,
                   output scl, scl_oe_n);
   modport slave  (input  lo, setup_req,
                   output setup_done);
endinterface

// file: hdl/scl_clock_gen.sv
`timescale 1ns/100ps
module scl_clock_gen
   import bist_regs_pkg::*;
(
   input  wire logic   i_core_clk,
   input  wire logic   i_rst,
   scl_timing_if.master tif
);

   typedef enum logic [1:0] {PH_IDLE, PH_HIGH, PH_LOW} phase_e;

   typedef struct packed {
      phase_e      phase;
      logic [7:0]  pre;
      logic [7:0]  cnt;
      logic [7:0]  len;
      logic [15:0] cyc;
      logic        scl;
   } gen_s;

   gen_s s_reg;
   gen_s s_next;
   logic tick;

   // Counts each phase down from its programmed value, one step per unit.
   always_comb begin
      s_next = s_reg;
      tick   = (s_reg.pre == 8'h00);
      s_next.pre = tick ? PRE_LOAD : s_reg.pre - 8'h01;
      s_next.cyc = s_reg.cyc + 16'h0001;
      case (s_reg.phase)
         PH_IDLE: begin
            s_next.scl = 1'b1;
            if (tif.master_en) begin
               s_next.phase = PH_HIGH;
               s_next.pre   = PRE_LOAD;
               s_next.cnt   = at_least_one(tif.hi);
               s_next.len   = at_least_one(tif.hi);
               s_next.cyc   = 16'h0001;
            end
         end
         PH_HIGH: begin
            if (tick && s_reg.cnt == 8'h01) begin
               if (!tif.master_en) begin
                  s_next.phase = PH_IDLE;
               end else begin
                  s_next.phase = PH_LOW;
                  s_next.scl   = 1'b0;
                  s_next.cnt   = at_least_one(tif.lo);
                  s_next.len   = at_least_one(tif.lo);
                  s_next.cyc   = 16'h0001;
               end
            end else if (tick) begin
               s_next.cnt = s_reg.cnt - 8'h01;
            end
         end
         PH_LOW: begin
            if (tick && s_reg.cnt == 8'h01) begin
               s_next.phase = PH_HIGH;
               s_next.scl   = 1'b1;
               s_next.cnt   = at_least_one(tif.hi);
               s_next.len   = at_least_one(tif.hi);
               s_next.cyc   = 16'h0001;
            end else if (tick) begin
               s_next.cnt = s_reg.cnt - 8'h01;
            end
         end
         default: s_next.phase = PH_IDLE;
      endcase
   end

   // State register; the line idles released and high.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s_reg <= '{phase: PH_IDLE, pre: 8'h00, cnt: 8'h00, len: 8'h00,
                    cyc: 16'h0000, scl: 1'b1};
      end else begin
         s_reg <= s_next;
      end
   end

   // Open-drain style: driving low exactly while the level is low.
   assign tif.scl      = s_reg.scl;
   assign tif.scl_oe_n = s_reg.scl;

   a_high_width :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      $fell(s_reg.scl) |-> 32'($past(s_reg.cyc)) == 32'($past(s_reg.len)) * SCL_UNIT_CYC)
      else $error("SCL high phase has the wrong length");

   a_low_width :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      $rose(s_reg.scl) |-> 32'($past(s_reg.cyc)) == 32'($past(s_reg.len)) * SCL_UNIT_CYC)
      else $error("SCL low phase has the wrong length");

endmodule // scl_clock_gen

// file: hdl/slave_setup_delay.sv
`timescale 1ns/100ps
module slave_setup_delay
   import bist_regs_pkg::*;
(
   input  wire logic  i_core_clk,
   input  wire logic  i_rst,
   scl_timing_if.slave tif
);

   typedef enum logic {SU_IDLE, SU_WAIT} setup_e;

   typedef struct packed {
      setup_e      state;
      logic [7:0]  pre;
      logic [7:0]  cnt;
      logic [7:0]  len;
      logic [15:0] cyc;
      logic        done;
   } setup_s;

   setup_s s_reg;
   setup_s s_next;
   logic   tick;

   // Counts the low-time count after a setup request, then pulses setup_done.
   always_comb begin
      s_next      = s_reg;
      tick        = (s_reg.pre == 8'h00);
      s_next.pre  = tick ? PRE_LOAD : s_reg.pre - 8'h01;
      s_next.cyc  = s_reg.cyc + 16'h0001;
      s_next.done = 1'b0;
      case (s_reg.state)
         SU_IDLE: begin
            if (tif.setup_req) begin
               s_next.state = SU_WAIT;
               s_next.pre   = PRE_LOAD;
               s_next.cnt   = at_least_one(tif.lo);
               s_next.len   = at_least_one(tif.lo);
               s_next.cyc   = 16'h0001;
            end
         end
         SU_WAIT: begin
            if (tick && s_reg.cnt == 8'h01) begin
               s_next.state = SU_IDLE;
               s_next.done  = 1'b1;
            end else if (tick) begin
               s_next.cnt = s_reg.cnt - 8'h01;
            end
         end
         default: s_next.state = SU_IDLE;
      endcase
   end

   // State register.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s_reg <= '{state: SU_IDLE, pre: 8'h00, cnt: 8'h00, len: 8'h00,
                    cyc: 16'h0000, done: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign tif.setup_done = s_reg.done;

   a_setup_delay :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      $rose(s_reg.done) |-> 32'($past(s_reg.cyc)) == 32'($past(s_reg.len)) * SCL_UNIT_CYC)
      else $error("Slave SDA setup interval has the wrong length");

endmodule // slave_setup_delay

// file: hdl/bist_i2c_timing_audio_regs.sv
`timescale 1ns/100ps
module bist_i2c_timing_audio_regs
   import bist_regs_pkg::*;
(
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   // Decoded accesses from the serial control bus.
   input  wire logic [7:0] i_reg_addr,
   input  wire logic       i_reg_wr,
   input  wire logic [7:0] i_reg_wdata,
   input  wire logic       i_reg_rd,
   output logic      [7:0] o_reg_rdata,
   // Self-test control and results.
   input  wire logic       i_powerdown_input_n,
   input  wire logic       i_selftest_pin,
   input  wire logic       i_selftest_pin_cfg,
   input  wire logic       i_selftest_run_bit,
   input  wire logic       i_fc_error,
   // Forward-channel load of the audio path control register.
   input  wire logic       i_fc_load,
   input  wire logic [7:0] i_fc_data,
   // Audio sources and link state.
   input  wire logic       i_transport_frame,
   input  wire logic       i_repeater_mode,
   input  wire logic       i_inband_valid,
   input  wire logic       i_inband_surround,
   input  wire logic [3:0] i_i2s_data,
   input  wire logic       i_i2s_ws,
   input  wire logic       i_aux_data,
   input  wire logic       i_aux_ws,
   input  wire logic [1:0] i_gpio_out,
   output logic      [3:0] o_i2s_data,
   output logic            o_i2s_ws,
   output logic      [1:0] o_gpio_out,
   output logic            o_aux_i2s_en,
   output logic            o_surround_en,
   // Local I2C timing.
   input  wire logic       i_master_en,
   input  wire logic       i_setup_req,
   output logic            o_scl_o,
   output logic            o_scl_oe_n,
   output logic            o_setup_done
);

   typedef struct packed {
      logic [7:0] err_cnt;
      logic       run;
      logic [7:0] hi;
      logic [7:0] lo;
      logic [7:0] audio;
      logic [7:0] rdata;
      logic [3:0] i2s_data;
      logic       i2s_ws;
      logic [1:0] gpio;
      logic       aux_en;
      logic       surround;
   } top_s;

   top_s s_reg;
   top_s s_next;
   logic run_src;
   logic run_start;
   logic wr_audio;
   logic surround_sel;

   scl_timing_if tif ();

   // Register file, self-test counter and audio output steering.
   always_comb begin
      s_next       = s_reg;
      run_src      = i_selftest_pin_cfg ? i_selftest_pin
                                        : i_selftest_run_bit;
      run_start    = run_src && !s_reg.run;
      s_next.run   = run_src;
      wr_audio     = i_reg_wr && (i_reg_addr == AUDIO_CTRL_ADDR);

      // Error counter; software reads it once the run has ended.
      if (!i_powerdown_input_n || run_start) begin
         s_next.err_cnt = ERR_CNT_RST;
      end else if (run_src && i_fc_error) begin
         s_next.err_cnt = sat_inc(s_reg.err_cnt);
      end

      // Writable timing fields.
      if (i_reg_wr && i_reg_addr == HIGH_TIME_ADDR) begin
         s_next.hi = i_reg_wdata;
      end
      if (i_reg_wr && i_reg_addr == LOW_TIME_ADDR) begin
         s_next.lo = i_reg_wdata;
      end

      // A local write wins over a forward-channel load in the same cycle.
      if (wr_audio) begin
         s_next.audio = i_reg_wdata & AUDIO_CTRL_MASK;
      end else if (i_fc_load && !s_reg.audio[FC_BLOCK_BIT]) begin
         s_next.audio = i_fc_data & AUDIO_CTRL_MASK;
      end

      // Read data; unmapped offsets and reserved bits read as zero.
      if (i_reg_rd) begin
         case (i_reg_addr)
            ERR_CNT_ADDR:    s_next.rdata = s_reg.err_cnt;
            HIGH_TIME_ADDR:  s_next.rdata = s_reg.hi;
            LOW_TIME_ADDR:   s_next.rdata = s_reg.lo;
            AUDIO_CTRL_ADDR: s_next.rdata = s_reg.audio;
            default:         s_next.rdata = 8'h00;
         endcase
      end

      // Auxiliary channel on the two low GPIO pins.
      s_next.aux_en = s_reg.audio[AUX_I2S_BIT];
      s_next.gpio   = s_reg.audio[AUX_I2S_BIT] ? {i_aux_ws, i_aux_data}
                                               : i_gpio_out;

      // Global I2S disable.
      s_next.i2s_data = s_reg.audio[I2S_OFF_BIT] ? 4'h0 : i_i2s_data;
      s_next.i2s_ws   = s_reg.audio[I2S_OFF_BIT] ? 1'b0 : i_i2s_ws;

      // Surround selection, repeater override, then transport restriction.
      surround_sel = (i_repeater_mode && i_inband_valid) ? i_inband_surround
                                                         : s_reg.audio[SURROUND_BIT];
      s_next.surround = surround_sel && !i_transport_frame;
   end

   // State register with documented reset values.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s_reg <= '{err_cnt: ERR_CNT_RST, run: 1'b0, hi: HIGH_TIME_RST,
                    lo: LOW_TIME_RST, audio: AUDIO_CTRL_RST, rdata: 8'h00,
                    i2s_data: 4'h0, i2s_ws: 1'b0, gpio: 2'b00,
                    aux_en: 1'b0, surround: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   // Timing values and requests to the two SCL timers.
   assign tif.hi        = s_reg.hi;
   assign tif.lo        = s_reg.lo;
   assign tif.master_en = i_master_en;
   assign tif.setup_req = i_setup_req;

   scl_clock_gen u_master (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .tif        (tif.master)
   );

   slave_setup_delay u_slave (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .tif        (tif.slave)
   );

   // Outputs, each from a flip-flop.
   assign o_reg_rdata   = s_reg.rdata;
   assign o_i2s_data    = s_reg.i2s_data;
   assign o_i2s_ws      = s_reg.i2s_ws;
   assign o_gpio_out    = s_reg.gpio;
   assign o_aux_i2s_en  = s_reg.aux_en;
   assign o_surround_en = s_reg.surround;
   assign o_scl_o       = tif.scl;
   assign o_scl_oe_n    = tif.scl_oe_n;
   assign o_setup_done  = tif.setup_done;

   // Self-test counter, run-source, forward-channel and audio routing checks.
   a_err_count_up :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_powerdown_input_n && run_src && s_reg.run && i_fc_error
       && s_reg.err_cnt != ERR_CNT_MAX)
      |=> s_reg.err_cnt == $past(s_reg.err_cnt) + 8'h01)
      else $error("Error count did not advance on a self-test error");

   a_err_saturates :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_powerdown_input_n && s_reg.run && s_reg.err_cnt == ERR_CNT_MAX)
      |=> s_reg.err_cnt == ERR_CNT_MAX)
      else $error("Error count wrapped past its maximum");

   a_err_pd_clear :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      !i_powerdown_input_n |=> s_reg.err_cnt == 8'h00)
      else $error("Power-down did not clear the error count");

   a_err_start_clear :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      (run_src && !s_reg.run) |=> s_reg.err_cnt == 8'h00)
      else $error("Start of a self-test run did not clear the count");

   a_run_from_pin :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_selftest_pin_cfg && !i_selftest_pin && i_fc_error)
      |=> $stable(s_reg.err_cnt) || s_reg.err_cnt == 8'h00)
      else $error("Run control ignored the dedicated pin");

   a_run_from_bit :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      (!i_selftest_pin_cfg && !i_selftest_run_bit && i_fc_error)
      |=> $stable(s_reg.err_cnt) || s_reg.err_cnt == 8'h00)
      else $error("Run control ignored the register bit");

   a_fc_blocked :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      (s_reg.audio[FC_BLOCK_BIT] && i_fc_load && !wr_audio) |=> $stable(s_reg.audio))
      else $error("Forward channel loaded a blocked register");

   a_fc_loaded :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      (!s_reg.audio[FC_BLOCK_BIT] && i_fc_load && !wr_audio)
      |=> s_reg.audio == ($past(i_fc_data) & AUDIO_CTRL_MASK))
      else $error("Forward channel load was not applied");

   a_aux_on_gpio :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      s_reg.audio[AUX_I2S_BIT] |=> o_gpio_out == {$past(i_aux_ws), $past(i_aux_data)})
      else $error("Aux I2S not routed to GPIO pins");

   a_i2s_muted :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      s_reg.audio[I2S_OFF_BIT] |=> o_i2s_data == 4'h0 && !o_i2s_ws)
      else $error("I2S outputs active while disabled");

   a_surround_sel :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      (!i_repeater_mode && !i_transport_frame)
      |=> o_surround_en == $past(s_reg.audio[SURROUND_BIT]))
      else $error("Surround output does not follow its bit");

   a_no_frame_surround :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_transport_frame |=> !o_surround_en)
      else $error("Surround carried with frame transport");

   a_repeater_override :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_repeater_mode && i_inband_valid && !i_transport_frame)
      |=> o_surround_en == $past(i_inband_surround))
      else $error("Repeater in-band surround override not applied");

   a_repeater_no_inband :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_repeater_mode && !i_inband_valid && !i_transport_frame)
      |=> o_surround_en == $past(s_reg.audio[SURROUND_BIT]))
      else $error("Surround overridden without in-band detection");

   // Stored values, read-back and pass-through paths.
   a_err_idle_hold :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_powerdown_input_n && !run_src) |=> $stable(s_reg.err_cnt))
      else $error("Error count moved outside a self-test run");

   a_count_read :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_reg_rd && i_reg_addr == ERR_CNT_ADDR) |=> o_reg_rdata == $past(s_reg.err_cnt))
      else $error("Error count read back the wrong value");

   a_high_write :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_reg_wr && i_reg_addr == HIGH_TIME_ADDR) |=> s_reg.hi == $past(i_reg_wdata))
      else $error("High-time write was not stored");

   a_low_write :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_reg_wr && i_reg_addr == LOW_TIME_ADDR) |=> s_reg.lo == $past(i_reg_wdata))
      else $error("Low-time write was not stored");

   a_local_write :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      wr_audio |=> s_reg.audio == ($past(i_reg_wdata) & AUDIO_CTRL_MASK))
      else $error("Local audio control write was not stored");

   a_aux_en_follows :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      1'b1 |=> o_aux_i2s_en == $past(s_reg.audio[AUX_I2S_BIT]))
      else $error("Aux enable does not follow its bit");

   a_gpio_plain :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      !s_reg.audio[AUX_I2S_BIT] |=> o_gpio_out == $past(i_gpio_out))
      else $error("GPIO pins lost their normal function");

   a_i2s_passes :
   assert property (@(posedge i_core_clk) disable iff (i_rst)
      !s_reg.audio[I2S_OFF_BIT]
      |=> o_i2s_data == $past(i_i2s_data) && o_i2s_ws == $past(i_i2s_ws))
      else $error("Enabled I2S outputs do not follow their sources");

endmodule // bist_i2c_timing_audio_regs

// file: bench/serial_host_model.sv
`timescale 1ns/100ps
module serial_host_model (
   input  wire logic       i_core_clk,
   input  wire logic [7:0] i_reg_rdata,
   output logic      [7:0] o_reg_addr,
   output logic            o_reg_wr,
   output logic      [7:0] o_reg_wdata,
   output logic            o_reg_rd
);
   // The bus starts idle with no strobe raised.
   initial begin
      o_reg_addr  = 8'h00;
      o_reg_wr    = 1'b0;
      o_reg_wdata = 8'h00;
      o_reg_rd    = 1'b0;
   end

   // One write: strobe held for one sampling edge, then data is scrambled.
   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge i_core_clk);
      o_reg_addr  <= addr;
      o_reg_wdata <= data;
      o_reg_wr    <= 1'b1;
      @(posedge i_core_clk);
      o_reg_wr    <= 1'b0;
      o_reg_wdata <= ~data;
   endtask

   // One read: the answer is taken once it has settled after the read edge.
   task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge i_core_clk);
      o_reg_addr <= addr;
      o_reg_rd   <= 1'b1;
      @(posedge i_core_clk);
      o_reg_rd   <= 1'b0;
      o_reg_addr <= ~addr;
      @(posedge i_core_clk);
      #1;
      data = i_reg_rdata;
   endtask
endmodule // serial_host_model

// file: bench/bist_i2c_timing_audio_regs_tb.sv
`timescale 1ns/100ps
module bist_i2c_timing_audio_regs_tb;
   import bist_regs_pkg::*;
   logic       i_core_clk, i_rst, reg_wr, reg_rd, pd_n, st_pin, st_cfg, st_bit, fc_err;
   logic       fc_load, frame, rep, ib_v, ib_s, i2s_ws, aux_d, aux_ws, men, sreq;
   logic [7:0] reg_addr, reg_wdata, rdata, fc_data, d;
   logic [3:0] i2s_d, o_i2s_d;
   logic [1:0] gpio, o_gpio;
   logic       o_ws, o_aux, o_sur, scl, scl_oe_n, sdone;
   int         num_errors, checks_done, cycles, i, n;
   logic [7:0] addrs [5] = '{ERR_CNT_ADDR, HIGH_TIME_ADDR, LOW_TIME_ADDR, AUDIO_CTRL_ADDR, 8'h30};
   logic [7:0] rsts [5]  = '{ERR_CNT_RST, HIGH_TIME_RST, LOW_TIME_RST, AUDIO_CTRL_RST, 8'h00};

   bist_i2c_timing_audio_regs dut_u (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
      .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd), .o_reg_rdata(rdata),
      .i_powerdown_input_n(pd_n), .i_selftest_pin(st_pin), .i_selftest_pin_cfg(st_cfg),
      .i_selftest_run_bit(st_bit), .i_fc_error(fc_err), .i_fc_load(fc_load),
      .i_fc_data(fc_data), .i_transport_frame(frame), .i_repeater_mode(rep),
      .i_inband_valid(ib_v), .i_inband_surround(ib_s), .i_i2s_data(i2s_d),
      .i_i2s_ws(i2s_ws), .i_aux_data(aux_d), .i_aux_ws(aux_ws), .i_gpio_out(gpio),
      .o_i2s_data(o_i2s_d), .o_i2s_ws(o_ws), .o_gpio_out(o_gpio), .o_aux_i2s_en(o_aux),
      .o_surround_en(o_sur), .i_master_en(men), .i_setup_req(sreq), .o_scl_o(scl),
      .o_scl_oe_n(scl_oe_n), .o_setup_done(sdone));

   serial_host_model host_u (
      .i_core_clk(i_core_clk), .i_reg_rdata(rdata), .o_reg_addr(reg_addr),
      .o_reg_wr(reg_wr), .o_reg_wdata(reg_wdata), .o_reg_rd(reg_rd));

   // Free-running core clock.
   initial begin
      i_core_clk = 1'b0;
      forever #50 i_core_clk = ~i_core_clk;
   end

   // A hung run is cut short and counted as a mismatch.
   always @(posedge i_core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         finish_test();
      end
   end

   task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp, input string msg);
      check_val({7'h00, got}, {7'h00, exp}, msg);
   endtask

   // Reads a register and compares it.
   task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
      host_u.reg_read(addr, d);
      check_val(d, exp, "register read");
   endtask

   // Error pulses with a gap between them.
   task automatic errs(input int cnt);
      repeat (cnt) begin
         @(posedge i_core_clk);
         fc_err <= 1'b1;
         @(posedge i_core_clk);
         fc_err <= 1'b0;
      end
   endtask

   // Lets a register change reach the registered outputs.
   task automatic settle();
      repeat (3) @(posedge i_core_clk);
      #1;
   endtask

   // Measures one SCL phase of the given level, checking the enable tracks it.
   task automatic phase_len(input logic lvl, output int len);
      len = 0;
      for (int k = 0; k < 300 && scl !== lvl; k++) begin
         @(posedge i_core_clk);
         #1;
      end
      while (scl === lvl && len < 300) begin
         check_bit(scl_oe_n, scl, "scl enable");
         len++;
         @(posedge i_core_clk);
         #1;
      end
   endtask

   task automatic finish_test();
      $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence of register, self-test, audio and timing scenarios.
   initial begin
      num_errors = 0; checks_done = 0; cycles = 0;
      i_rst = 1'b1; pd_n = 1'b1; st_pin = 1'b0; st_cfg = 1'b1; st_bit = 1'b0;
      fc_err = 1'b0; fc_load = 1'b0; fc_data = 8'h00; frame = 1'b0; rep = 1'b0;
      ib_v = 1'b0; ib_s = 1'b0; i2s_d = 4'ha; i2s_ws = 1'b1; aux_d = 1'b1;
      aux_ws = 1'b0; gpio = 2'b10; men = 1'b0; sreq = 1'b0;
      repeat (5) @(posedge i_core_clk);
      i_rst <= 1'b0;
      @(posedge i_core_clk);
      for (i = 0; i < 5; i++) read_check(addrs[i], rsts[i]);
      host_u.reg_write(ERR_CNT_ADDR, 8'h5a);
      read_check(ERR_CNT_ADDR, 8'h00);
      host_u.reg_write(AUDIO_CTRL_ADDR, 8'hff);
      read_check(AUDIO_CTRL_ADDR, 8'h8d);
      @(posedge i_core_clk);
      fc_load <= 1'b1;
      fc_data <= 8'h00;
      @(posedge i_core_clk);
      fc_load <= 1'b0;
      read_check(AUDIO_CTRL_ADDR, 8'h8d);
      host_u.reg_write(AUDIO_CTRL_ADDR, 8'h00);
      @(posedge i_core_clk);
      fc_load <= 1'b1;
      fc_data <= 8'h7d;
      @(posedge i_core_clk);
      fc_load <= 1'b0;
      read_check(AUDIO_CTRL_ADDR, 8'h0d);
      host_u.reg_write(AUDIO_CTRL_ADDR, 8'h00);
      // Errors outside a run are dropped; the pin runs the test by default.
      errs(2);
      st_pin <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      errs(3);
      st_cfg <= 1'b0;
      errs(4);
      read_check(ERR_CNT_ADDR, 8'h03);
      st_bit <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      errs(2);
      st_bit <= 1'b0;
      read_check(ERR_CNT_ADDR, 8'h02);
      st_bit <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      errs(260);
      st_bit <= 1'b0;
      read_check(ERR_CNT_ADDR, 8'hff);
      @(posedge i_core_clk);
      pd_n <= 1'b0;
      @(posedge i_core_clk);
      pd_n <= 1'b1;
      read_check(ERR_CNT_ADDR, 8'h00);
      // Audio output gating and routing.
      host_u.reg_write(AUDIO_CTRL_ADDR, 8'h08);
      settle();
      check_val({6'h00, o_gpio}, 8'h01, "aux on gpio");
      check_bit(o_aux, 1'b1, "aux enable");
      host_u.reg_write(AUDIO_CTRL_ADDR, 8'h04);
      settle();
      check_val({3'h0, o_ws, o_i2s_d}, 8'h00, "i2s off");
      check_val({6'h00, o_gpio}, 8'h02, "plain gpio");
      check_bit(o_aux, 1'b0, "aux disable");
      host_u.reg_write(AUDIO_CTRL_ADDR, 8'h01);
      settle();
      check_val({3'h0, o_ws, o_i2s_d}, 8'h1a, "i2s on");
      check_bit(o_sur, 1'b1, "surround");
      frame <= 1'b1;
      settle();
      check_bit(o_sur, 1'b0, "surround with frame");
      frame <= 1'b0;
      rep <= 1'b1;
      ib_v <= 1'b1;
      settle();
      check_bit(o_sur, 1'b0, "inband stereo");
      host_u.reg_write(AUDIO_CTRL_ADDR, 8'h00);
      ib_s <= 1'b1;
      settle();
      check_bit(o_sur, 1'b1, "inband surround");
      ib_v <= 1'b0;
      settle();
      check_bit(o_sur, 1'b0, "no inband");
      rep <= 1'b0;
      // Master clock phases follow the programmed counts.
      host_u.reg_write(HIGH_TIME_ADDR, 8'h02);
      host_u.reg_write(LOW_TIME_ADDR, 8'h03);
      men <= 1'b1;
      phase_len(1'b0, n);
      check_val(8'(n), 8'h03, "scl low");
      phase_len(1'b1, n);
      check_val(8'(n), 8'h02, "scl high");
      men <= 1'b0;
      repeat (12) @(posedge i_core_clk);
      #1;
      check_bit(scl, 1'b1, "scl idle");
      check_bit(scl_oe_n, 1'b1, "scl released");
      // Slave setup interval uses the low count.
      @(posedge i_core_clk);
      sreq <= 1'b1;
      @(posedge i_core_clk);
      sreq <= 1'b0;
      n = 0;
      #1;
      while (sdone !== 1'b1 && n < 300) begin
         @(posedge i_core_clk);
         n++;
         #1;
      end
      check_val(8'(n), 8'h03, "setup interval");
      finish_test();
   end
endmodule // bist_i2c_timing_audio_regs_tb
